// ### amst_pkg.sv
`default_nettype none
package amst_pkg;

  // ********************************
  // register indices (byte address = index * 4)
  // ********************************
  localparam logic [9:0] IDX_SUMMARY = 10'h2C0;
  localparam logic [9:0] IDX_ALERT_STATUS = 10'h2C1;
  localparam logic [9:0] IDX_ALARM_MASK = 10'h2C2;
  localparam logic [9:0] IDX_LANE_FIFO_ALARM = 10'h2C4;
  localparam logic [9:0] IDX_CORE_CTRL = 10'h300;
  localparam logic [9:0] IDX_TRIM_A = 10'h310;
  localparam logic [9:0] IDX_TRIM_B = 10'h313;

  // ********************************
  // field positions
  // ********************************
  localparam int BIT_LANE_OVERFLOW = 5;
  localparam int BIT_LOCK_LOST = 4;
  localparam int BIT_SERIAL_LINK = 3;
  localparam int BIT_CLOCK_REALIGN = 2;
  localparam int BIT_UNUSED_OSC = 1;
  localparam int BIT_DIVIDER_MISMATCH = 0;
  localparam int BIT_DUAL_MODE = 0;
  localparam int BIT_FG_CAL_EN = 1;

  // ********************************
  // reset values and masks
  // ********************************
  localparam logic [7:0] RST_ALARM_MASK = 8'h3F;
  localparam logic [5:0] RST_ALERT_STATUS = 6'h3F;
  localparam logic [15:0] RST_LANE_FIFO_ALARM = 16'hFFFF;
  localparam logic [7:0] RST_TRIM = 8'h00;
  localparam logic [1:0] RST_CORE_CTRL = 2'h0;
  // flags allowed to reach the summary bit; the oscillator flag never does
  localparam logic [5:0] ALERT_USED = 6'h3D;

  // ********************************
  // carriers
  // ********************************
  typedef struct packed {
    logic lock_lost;
    logic serial_link;
    logic clock_realign;
    logic divider_mismatch;
  } amst_alarm_src_t;

  typedef struct packed {
    logic [7:0] code_a;
    logic apply_a;
    logic [7:0] code_b;
    logic apply_b;
  } amst_trim_out_t;

endpackage
`default_nettype wire

// ### amst_flag_bank.sv
`default_nettype none
module amst_flag_bank #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic clk_i, // register clock
  input wire logic sys_rst_i, // async reset, high
  input wire logic [WIDTH-1:0] set_i, // hardware events
  input wire logic [WIDTH-1:0] clr_i, // write-one-to-clear strobes
  input wire logic clr_all_i, // clear every flag
  output logic [WIDTH-1:0] flags_o // sticky flags
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // set wins over clear so a persisting fault re-trips at once
  assign flags_next = (flags_reg & ~(clr_i | {WIDTH{clr_all_i}})) | set_i;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      flags_reg <= RESET_VAL;
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

  assign flags_o = flags_reg;

endmodule
`default_nettype wire

// ### amst_alarm_trim.sv
// Added by the designer: the APB slave port.
`default_nettype none
// Behaviour
// RQ1 - mask register resets to 0x3F, all alarms masked
// RQ2 - mask bit 5 keeps lane overflow flag off the summary bit
// RQ3 - mask bit 4 keeps lock-lost flag off the summary bit
// RQ4 - mask bit 3 keeps serial link flag off the summary bit
// RQ5 - mask bit 2 keeps clock realign flag off the summary bit
// RQ6 - mask bit 0 keeps divider mismatch flag off the summary bit
// RQ7 - mask bit 1 only stores; the oscillator flag never alerts
// RQ8 - lane flag i sets on overflow or underflow of lane i
// RQ9 - writing one clears a lane flag; zero keeps it
// RQ10 - persisting lane fault sets the flag again right after clearing
// RQ11 - writing one to status bit 5 clears all lane flags
// RQ12 - lane flag register resets to all ones
// RQ13 - each 8-bit trim code shifts its core's sampling instant
// RQ14 - trims load factory values, readable and writable by software
// RQ15 - A trim applies only in dual-channel mode
// RQ16 - B trim applies in dual-channel mode with foreground calibration
// RQ17 - summary bit is one when any unmasked status flag is set; the code leaves status bit 1 out even when it is set and unmasked
// RQ18 - aggregate lane flag sets when any active lane faults
// RQ19 - status flags clear on write-one and reset to one
// RQ20 - mask change reaches summary bit within one cycle
module amst_alarm_trim #(
  parameter int LANES = 16
) (
  input wire logic clk_i, // register clock, 250 MHz
  input wire logic sys_rst_i, // async reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire amst_pkg::amst_alarm_src_t alarm_src_i, // alarm events
  input wire logic [LANES-1:0] lane_fault_i, // lane fifo over/underflow
  input wire logic [LANES-1:0] lane_active_i, // lanes in use
  input wire logic fuse_load_i, // factory trim load pulse
  input wire logic [7:0] fuse_trim_a_i, // factory trim, core A
  input wire logic [7:0] fuse_trim_b_i, // factory trim, core B
  output var amst_pkg::amst_trim_out_t trim_o, // applied trim codes
  output logic alert_o // summary alert
);

  // ********************************
  // apb decode
  // ********************************
  logic [9:0] word_idx;
  logic aligned;
  logic setup_phase;
  logic wr_en;
  logic hit_summary, hit_status, hit_mask, hit_lane, hit_ctrl, hit_ta, hit_tb;
  logic mapped;

  assign word_idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup_phase = psel && !penable;
  assign pready = psel && penable;
  assign wr_en = psel && penable && pwrite;

  assign hit_summary = aligned && (word_idx == amst_pkg::IDX_SUMMARY);
  assign hit_status = aligned && (word_idx == amst_pkg::IDX_ALERT_STATUS);
  assign hit_mask = aligned && (word_idx == amst_pkg::IDX_ALARM_MASK);
  assign hit_lane = aligned && (word_idx == amst_pkg::IDX_LANE_FIFO_ALARM);
  assign hit_ctrl = aligned && (word_idx == amst_pkg::IDX_CORE_CTRL);
  assign hit_ta = aligned && (word_idx == amst_pkg::IDX_TRIM_A);
  assign hit_tb = aligned && (word_idx == amst_pkg::IDX_TRIM_B);
  assign mapped = hit_summary || hit_status || hit_mask || hit_lane ||
                  hit_ctrl || hit_ta || hit_tb;

  // ********************************
  // registers
  // ********************************
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [1:0] ctrl_reg;
  logic [1:0] ctrl_next;
  logic [7:0] trim_a_reg;
  logic [7:0] trim_a_next;
  logic [7:0] trim_b_reg;
  logic [7:0] trim_b_next;
  logic alert_reg;
  logic alert_next;
  amst_pkg::amst_trim_out_t trim_reg;
  amst_pkg::amst_trim_out_t trim_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic err_reg;

  logic [5:0] status_q;
  logic [5:0] status_set;
  logic [5:0] status_clr;
  logic [LANES-1:0] lane_q;
  logic [LANES-1:0] lane_clr;
  logic lane_clr_all;
  logic any_active_fault;
  logic [5:0] unmasked;

  // reserved bits 7:6 are plain storage
  assign mask_next = (wr_en && hit_mask) ? pwdata[7:0] : mask_reg;
  assign ctrl_next = (wr_en && hit_ctrl) ? pwdata[1:0] : ctrl_reg;
  // factory load takes priority over a coincident software write
  assign trim_a_next = fuse_load_i ? fuse_trim_a_i :
                       ((wr_en && hit_ta) ? pwdata[7:0] : trim_a_reg); // RQ14
  assign trim_b_next = fuse_load_i ? fuse_trim_b_i :
                       ((wr_en && hit_tb) ? pwdata[7:0] : trim_b_reg); // RQ14

  // ********************************
  // alarm status and lane flags
  // ********************************
  assign any_active_fault = |(lane_fault_i & lane_active_i); // RQ18
  // oscillator flag has no source in this device
  assign status_set = {any_active_fault, alarm_src_i.lock_lost,
                       alarm_src_i.serial_link, alarm_src_i.clock_realign,
                       1'b0, alarm_src_i.divider_mismatch};
  assign status_clr = (wr_en && hit_status) ? pwdata[5:0] : 6'h00; // RQ19
  assign lane_clr = (wr_en && hit_lane) ? pwdata[LANES-1:0] : '0; // RQ9
  assign lane_clr_all = wr_en && hit_status && pwdata[amst_pkg::BIT_LANE_OVERFLOW]; // RQ11

  amst_flag_bank #(
    .WIDTH(6),
    .RESET_VAL(amst_pkg::RST_ALERT_STATUS)
  ) u_status (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(status_set),
    .clr_i(status_clr),
    .clr_all_i(1'b0),
    .flags_o(status_q)
  );

  amst_flag_bank #(
    .WIDTH(LANES),
    .RESET_VAL(amst_pkg::RST_LANE_FIFO_ALARM[LANES-1:0]) // RQ12
  ) u_lane (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(lane_fault_i), // RQ8 RQ10
    .clr_i(lane_clr),
    .clr_all_i(lane_clr_all),
    .flags_o(lane_q)
  );

  // ********************************
  // summary alert
  // ********************************
  // mask bit 1 is left out by ALERT_USED, so it only stores
  assign unmasked = status_q & ~mask_reg[5:0] & amst_pkg::ALERT_USED; // RQ2 RQ3 RQ4 RQ5 RQ6 RQ7
  // uses the stored mask, so a write shows one edge later
  assign alert_next = |unmasked; // RQ17 RQ20

  // ********************************
  // trim application
  // ********************************
  always_comb
  begin
    trim_next = '0;
    trim_next.apply_a = ctrl_reg[amst_pkg::BIT_DUAL_MODE]; // RQ15
    trim_next.code_a = trim_next.apply_a ? trim_a_reg : amst_pkg::RST_TRIM; // RQ13
    trim_next.apply_b = ctrl_reg[amst_pkg::BIT_DUAL_MODE] &&
                        ctrl_reg[amst_pkg::BIT_FG_CAL_EN]; // RQ16
    trim_next.code_b = trim_next.apply_b ? trim_b_reg : amst_pkg::RST_TRIM; // RQ13
  end

  // ********************************
  // read mux, captured in the setup phase
  // ********************************
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (hit_summary)
    begin
      rdata_next = {31'h0000_0000, alert_reg};
    end
    else if (hit_status)
    begin
      rdata_next = {26'h000_0000, status_q};
    end
    else if (hit_mask)
    begin
      rdata_next = {24'h00_0000, mask_reg};
    end
    else if (hit_lane)
    begin
      rdata_next = {{(32-LANES){1'b0}}, lane_q};
    end
    else if (hit_ctrl)
    begin
      rdata_next = {30'h0000_0000, ctrl_reg};
    end
    else if (hit_ta)
    begin
      rdata_next = {24'h00_0000, trim_a_reg};
    end
    else if (hit_tb)
    begin
      rdata_next = {24'h00_0000, trim_b_reg};
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mask_reg <= amst_pkg::RST_ALARM_MASK; // RQ1
      ctrl_reg <= amst_pkg::RST_CORE_CTRL;
      trim_a_reg <= amst_pkg::RST_TRIM;
      trim_b_reg <= amst_pkg::RST_TRIM;
      alert_reg <= 1'b0;
      trim_reg <= '0;
    end
    else
    begin
      mask_reg <= mask_next;
      ctrl_reg <= ctrl_next;
      trim_a_reg <= trim_a_next;
      trim_b_reg <= trim_b_next;
      alert_reg <= alert_next;
      trim_reg <= trim_next;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end
    else if (setup_phase)
    begin
      rdata_reg <= rdata_next;
      err_reg <= !mapped;
    end
  end

  assign prdata = rdata_reg;
  assign pslverr = pready && err_reg;
  assign alert_o = alert_reg;
  assign trim_o = trim_reg;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // bare copies for $past, which is kept to plain signals
  logic [LANES-1:0] chk_lane_wdata;
  logic [7:0] chk_wbyte;
  logic [5:0] chk_status_wdata;
  logic chk_dual;
  logic chk_dual_fg;
  logic chk_alert_expect;

  assign chk_lane_wdata = pwdata[LANES-1:0];
  assign chk_wbyte = pwdata[7:0];
  assign chk_status_wdata = pwdata[5:0];
  assign chk_dual = ctrl_reg[0];
  assign chk_dual_fg = ctrl_reg[0] && ctrl_reg[1];
  // bit 1 never counts toward the summary, whatever its mask
  assign chk_alert_expect = |(status_q & ~mask_reg[5:0] & 6'h3D);

  logic first_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      first_reg <= 1'b1;
    end
    else
    begin
      first_reg <= 1'b0;
    end
  end

  sequence lane_wr_s;
    wr_en && hit_lane && (lane_fault_i == '0);
  endsequence

  sequence clr_all_s;
    lane_clr_all && (lane_fault_i == '0);
  endsequence

  sequence status_wr_s;
    wr_en && hit_status && (alarm_src_i == '0) && (lane_fault_i == '0);
  endsequence

  // setup on a hole in the map, then the access cycle
  sequence unmapped_access_s;
    (setup_phase && !mapped) ##1 (psel && penable);
  endsequence

  mask_reset_val_a: assert property (first_reg |-> mask_reg == 8'h3F) // RQ1
    else $error("mask not 0x3F after reset");
  lane_reset_val_a: assert property (first_reg |-> lane_q == '1) // RQ12
    else $error("lane flags not all ones after reset");
  status_reset_val_a: assert property (first_reg |-> status_q == 6'h3F) // RQ19
    else $error("status flags not 0x3F after reset");
  alert_follows_a: assert property (chk_alert_expect |=> alert_o) // RQ17
    else $error("summary alert does not follow unmasked flags");
  alert_quiet_a: assert property (!chk_alert_expect |=> !alert_o) // RQ17
    else $error("summary alert set with no unmasked flag");
  mask_write_alert_a: assert property ( // RQ20
    (wr_en && hit_mask) ##1 (status_q[5] && !mask_reg[5]) |=> alert_o)
    else $error("mask write not seen on alert within one cycle");
  mask_store_a: assert property ((wr_en && hit_mask) |=> mask_reg == $past(chk_wbyte)) // RQ7
    else $error("mask write not stored");
  lane_mask_block_a: assert property ((mask_reg[5:0] == 6'h3F) |=> !alert_o) // RQ2
    else $error("masked flags reach summary alert");
  osc_flag_ignored_a: assert property ( // RQ7
    (status_q[1] && !mask_reg[1] && !chk_alert_expect) |=> !alert_o)
    else $error("oscillator flag reached summary alert");
  lane_set_a: assert property ( // RQ8
    (lane_fault_i != '0) |=> ((lane_q & $past(lane_fault_i)) == $past(lane_fault_i)))
    else $error("lane flag not set by fault");
  lane_w1c_a: assert property ( // RQ9
    lane_wr_s |=> ((lane_q & $past(chk_lane_wdata)) == '0) &&
      ((lane_q | $past(chk_lane_wdata)) == ($past(lane_q) | $past(chk_lane_wdata))))
    else $error("lane write-one-to-clear wrong");
  lane_clear_all_a: assert property (clr_all_s |=> lane_q == '0) // RQ11
    else $error("status bit 5 write did not clear lane flags");
  status_w1c_a: assert property ( // RQ19
    status_wr_s |=> ((status_q & $past(chk_status_wdata)) == 6'h00))
    else $error("status write-one-to-clear wrong");
  aggr_flag_a: assert property (((lane_fault_i & lane_active_i) != '0) |=> status_q[5]) // RQ18
    else $error("aggregate lane flag not set");
  trim_fuse_a: assert property ( // RQ14
    fuse_load_i |=> (trim_a_reg == $past(fuse_trim_a_i)) &&
      (trim_b_reg == $past(fuse_trim_b_i)))
    else $error("factory trim not loaded");
  trim_a_apply_a: assert property ( // RQ15
    ##1 ((trim_o.apply_a == $past(chk_dual)) &&
      (!trim_o.apply_a || trim_o.code_a == $past(trim_a_reg))))
    else $error("core A trim applied outside dual mode");
  trim_b_apply_a: assert property ( // RQ16
    ##1 ((trim_o.apply_b == $past(chk_dual_fg)) &&
      (!trim_o.apply_b || trim_o.code_b == $past(trim_b_reg))))
    else $error("core B trim apply condition wrong");
  unmapped_err_a: assert property (
    unmapped_access_s |-> pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

endmodule
`default_nettype wire

// ### tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ********************************
  // stimulus and observed signals
  // ********************************
  localparam logic [11:0] A_SUM = {amst_pkg::IDX_SUMMARY, 2'b00};
  localparam logic [11:0] A_STAT = {amst_pkg::IDX_ALERT_STATUS, 2'b00};
  localparam logic [11:0] A_MSK = {amst_pkg::IDX_ALARM_MASK, 2'b00};
  localparam logic [11:0] A_LANE = {amst_pkg::IDX_LANE_FIFO_ALARM, 2'b00};
  localparam logic [11:0] A_CTL = {amst_pkg::IDX_CORE_CTRL, 2'b00};
  localparam logic [11:0] A_TA = {amst_pkg::IDX_TRIM_A, 2'b00};
  localparam logic [11:0] A_TB = {amst_pkg::IDX_TRIM_B, 2'b00};
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  amst_pkg::amst_alarm_src_t alarm_src_i = '0;
  logic [15:0] lane_fault_i = 16'h0000;
  logic [15:0] lane_active_i = 16'h0000;
  logic fuse_load_i = 1'b0;
  logic [7:0] fuse_trim_a_i = 8'h5A;
  logic [7:0] fuse_trim_b_i = 8'hA5;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  amst_pkg::amst_trim_out_t trim_o;
  logic alert_o;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int tests_run = 0;
  int bits[5] = '{5, 4, 3, 2, 0};

  always #2 clk_i = ~clk_i;

  amst_alarm_trim #(.LANES(16)) u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarm_src_i(alarm_src_i),
    .lane_fault_i(lane_fault_i), .lane_active_i(lane_active_i),
    .fuse_load_i(fuse_load_i), .fuse_trim_a_i(fuse_trim_a_i),
    .fuse_trim_b_i(fuse_trim_b_i), .trim_o(trim_o), .alert_o(alert_o)
  );

  // ********************************
  // bus and check helpers
  // ********************************
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      n_fail++;
    end
  endtask

  // request held until pready is sampled high, released only after that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask

  // registered outputs settle one edge after the write edge
  task automatic alert_chk(input logic e);
    @(posedge clk_i);
    #1;
    chk("alert_o", {31'h0, alert_o}, {31'h0, e});
  endtask

  task automatic trim_chk(input logic [17:0] e);
    @(posedge clk_i);
    #1;
    chk("trim_o", {14'h0, trim_o}, {14'h0, e});
  endtask

  task automatic pulse(input int b);
    @(posedge clk_i);
    case (b)
      5: lane_fault_i <= 16'h0001;
      4: alarm_src_i.lock_lost <= 1'b1;
      3: alarm_src_i.serial_link <= 1'b1;
      2: alarm_src_i.clock_realign <= 1'b1;
      default: alarm_src_i.divider_mismatch <= 1'b1;
    endcase
    @(posedge clk_i);
    lane_fault_i <= 16'h0000;
    alarm_src_i <= '0;
  endtask

  task automatic close_out;
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ********************************
  // test sequence
  // ********************************
  initial
  begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    alert_chk(1'b0);
    chk("trim_o", {14'h0, trim_o}, 32'h0);
    rdc("mask", A_MSK, 32'h3F);
    rdc("lane", A_LANE, 32'hFFFF);
    rdc("status", A_STAT, 32'h3F);
    rdc("trim_a", A_TA, 32'h0);
    rdc("trim_b", A_TB, 32'h0);
    wr(A_MSK, 32'h3D);
    alert_chk(1'b0);
    rdc("mask", A_MSK, 32'h3D);
    wr(A_LANE, 32'h00FF);
    rdc("lane", A_LANE, 32'hFF00);
    wr(A_STAT, 32'h20);
    rdc("lane", A_LANE, 32'h0);
    rdc("status", A_STAT, 32'h1F);
    wr(A_STAT, 32'h1F);
    rdc("status", A_STAT, 32'h0);
    @(posedge clk_i);
    lane_fault_i <= 16'h0008;
    wr(A_LANE, 32'h8);
    rdc("lane", A_LANE, 32'h8);
    rdc("status", A_STAT, 32'h0);
    @(posedge clk_i);
    lane_active_i <= 16'h0008;
    rdc("status", A_STAT, 32'h20);
    @(posedge clk_i);
    lane_fault_i <= 16'h0000;
    lane_active_i <= 16'hFFFF;
    foreach (bits[i])
    begin
      wr(A_MSK, 32'h3F);
      wr(A_STAT, 32'h3F);
      pulse(bits[i]);
      rdc("status", A_STAT, 32'h1 << bits[i]);
      alert_chk(1'b0);
      wr(A_MSK, 32'h3F & ~(32'h1 << bits[i]));
      alert_chk(1'b1);
      rdc("summary", A_SUM, 32'h1);
      wr(A_MSK, 32'h3F);
      alert_chk(1'b0);
    end
    wr(A_SUM, 32'h1);
    rdc("summary", A_SUM, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    @(posedge clk_i);
    fuse_load_i <= 1'b1;
    @(posedge clk_i);
    fuse_load_i <= 1'b0;
    rdc("trim_a", A_TA, 32'h5A);
    rdc("trim_b", A_TB, 32'hA5);
    trim_chk(18'h0);
    wr(A_CTL, 32'h1);
    trim_chk({8'h5A, 1'b1, 8'h00, 1'b0});
    wr(A_CTL, 32'h2);
    trim_chk(18'h0);
    wr(A_CTL, 32'h3);
    trim_chk({8'h5A, 1'b1, 8'hA5, 1'b1});
    wr(A_TA, 32'h33);
    trim_chk({8'h33, 1'b1, 8'hA5, 1'b1});
    rdc("trim_a", A_TA, 32'h33);
    close_out();
  end

  // full sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
